// ==== verilog/ccsb_defs.svh ====
// Constants for the card clock, character rate and clock-stop logic.
// Assumes a 10 MHz system clock sampling the terminal-supplied card clock.
`ifndef CCSB_DEFS_SVH
`define CCSB_DEFS_SVH

// System clock period in ns
`define CCSB_SYS_PERIOD_NS   100
// Longest card clock period (1 MHz floor) in ns
`define CCSB_MAX_CLK_NS      1000
// Sys cycles without a card clock edge before the clock counts as stopped
`define CCSB_STOP_CYC        (2 * `CCSB_MAX_CLK_NS / `CCSB_SYS_PERIOD_NS)
`define CCSB_STOP_W          5
// Card clocks per bit during answer-to-reset and by default
`define CCSB_ETU_DEFAULT     12'h174
`define CCSB_DIV_W           12
// Character framing: start, 8 data, parity, then 2 etu guard
`define CCSB_FRAME_BITS      4'ha
`define CCSB_GUARD_END       4'hc
// Receive activity window in etu (one character plus guard)
`define CCSB_RX_ETUS         4'hc
// Status words for normal completion
`define CCSB_SW1_OK          8'h90
`define CCSB_SW2_OK          8'h00
// Frequency requirement flag position in file characteristics byte 1
`define CCSB_FCHAR_FAST_BIT  2
// Synchroniser reset value: all ones, the idle level of the data pin, so no false edge follows reset
`define CCSB_SYNC_IDLE       3'h7

`endif

// ==== verilog/ccsb_pkg.sv ====
// Types for the card clock and character rate block.
// Constants live in ccsb_defs.svh.
`include "ccsb_defs.svh"

package ccsb_pkg;

    typedef enum logic [1:0] {
        CCSB_TX_IDLE  = 2'b00,
        CCSB_TX_BITS  = 2'b01,
        CCSB_TX_GUARD = 2'b10
    } ccsb_tx_st_t;

    typedef struct packed {
        logic [`CCSB_DIV_W-1:0] cnt;
        logic                   etu;
    } ccsb_etu_state_t;

    typedef struct packed {
        logic [2:0]             clk_sync;
        logic [2:0]             io_sync;
        logic [`CCSB_STOP_W-1:0] stop_cnt;
        logic                   clk_stopped;
        logic [`CCSB_DIV_W-1:0] div;
        ccsb_tx_st_t            tx_st;
        logic [9:0]             frame;
        logic [3:0]             bit_cnt;
        logic                   sleep_pend;
        logic                   sw2_pend;
        logic                   rx_busy;
        logic [3:0]             rx_cnt;
        logic                   io_oe;
        logic                   op_state;
    } ccsb_state_t;

endpackage

// ==== verilog/ccsb_etu_if.sv ====
// Link between the card controller and its bit-period generator.
// Both ends run on the same system clock.
`timescale 1ns/1ps
`include "ccsb_defs.svh"

interface ccsb_etu_if;
    import ccsb_pkg::*;
    logic                   clk_tick;
    logic                   restart;
    logic [`CCSB_DIV_W-1:0] div;
    logic                   etu_tick;

    modport gen  (input clk_tick, input restart, input div, output etu_tick);
    modport user (output clk_tick, output restart, output div, input etu_tick);
endinterface

// ==== verilog/ccsb_etu_gen.sv ====
// Bit-period generator: counts card clock edges, pulses once per etu.
// Assumes clk_tick is a one-cycle pulse per card clock rising edge.
`timescale 1ns/1ps
`include "ccsb_defs.svh"

module ccsb_etu_gen
    import ccsb_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk_in,
    input  wire logic reset_n_in,
    // Rate link
    ccsb_etu_if.gen   etu
);

    ccsb_etu_state_t s_r;
    ccsb_etu_state_t s_nxt;

    // Count card clocks; a stopped clock simply freezes the count
    always_comb begin
        s_nxt     = s_r;
        s_nxt.etu = 1'b0;
        if (etu.restart) begin
            s_nxt.cnt = '0;
        end else if (etu.clk_tick) begin
            if (s_r.cnt >= etu.div - `CCSB_DIV_W'(1)) begin
                s_nxt.cnt = '0;
                s_nxt.etu = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + `CCSB_DIV_W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign etu.etu_tick = s_r.etu;

endmodule

// ==== verilog/ccsb_card_ctrl.sv ====
// Card-side clock, activity state and character rate control.
// Assumes the terminal drives card_clk_in and pulls the open-drain data line up.
//
// Notes on behaviour
// - Run only on terminal clock, 1 to 5 MHz
// - Flag fast-clock need in characteristics byte 1
// - Operating while busy or on line, else idle
// - Idle or stopped clock keeps all state
// - Sleep command answered with normal status words
// - Answer-to-reset uses clock divided by 372
// - Keep 372 unless negotiation succeeded
`timescale 1ns/1ps
`include "ccsb_defs.svh"

module ccsb_card_ctrl
    import ccsb_pkg::*;
(
    // Clock and reset
    input  wire logic                   sys_clk_in,
    input  wire logic                   reset_n_in,
    // Card pins
    input  wire logic                   card_clk_in,
    input  wire logic                   io_in,
    output logic                        io_out,
    output logic                        io_oe_out,
    // Card core side
    input  wire logic                   cmd_busy_in,
    input  wire logic                   atr_active_in,
    input  wire logic                   pps_ok_in,
    input  wire logic [`CCSB_DIV_W-1:0] pps_div_in,
    input  wire logic                   needs_fast_clk_in,
    input  wire logic                   sleep_ok_in,
    input  wire logic                   tx_valid_in,
    input  wire logic [7:0]             tx_data_in,
    output logic                        tx_ready_out,
    // Status
    output logic [7:0]                  fchar_byte1_out,
    output logic                        op_state_out,
    output logic                        clk_stopped_out,
    output logic                        rx_busy_out,
    output logic [`CCSB_DIV_W-1:0]      etu_div_out
);

    ccsb_state_t s_r;
    ccsb_state_t s_nxt;
    ccsb_etu_if  etu ();
    logic        clk_edge;
    logic        io_fall;

    // Build a direct-convention frame: start, data LSB first, even parity
    function automatic logic [9:0] mk_frame(input logic [7:0] d);
        mk_frame = {^d, d, 1'b0};
    endfunction

    // Four-bit counter step shared by the bit and window counters
    function automatic logic [3:0] nib_inc(input logic [3:0] v);
        nib_inc = v + 4'h1;
    endfunction

    // Edges seen only after the two-stage synchronisers
    assign clk_edge = s_r.clk_sync[1] & ~s_r.clk_sync[2];
    assign io_fall  = ~s_r.io_sync[1] & s_r.io_sync[2];

    // Status words take the line ahead of user data
    // Combinational, so a request is taken on the edge where it is seen
    assign tx_ready_out = (s_r.tx_st == CCSB_TX_IDLE) && !s_r.sleep_pend
                          && !s_r.sw2_pend && !s_r.rx_busy;

    // Bit-period generator shares the card clock ticks
    // One divisor for both directions, so a rate change applies to both
    assign etu.clk_tick = clk_edge;
    assign etu.div      = s_r.div;

    // Restart the bit timer on every character start; held off in a receive
    // window, else a queued status word would freeze the window count
    always_comb begin
        etu.restart = 1'b0;
        if (s_r.tx_st == CCSB_TX_IDLE && !s_r.rx_busy) begin
            etu.restart = io_fall || tx_valid_in || s_r.sleep_pend || s_r.sw2_pend;
        end
    end

    ccsb_etu_gen u_etu (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .etu        (etu.gen)
    );

    // Next-state logic for the whole controller
    always_comb begin
        s_nxt = s_r;

        // Pin synchronisers; first stage feeds only the second
        s_nxt.clk_sync = {s_r.clk_sync[1:0], card_clk_in};
        s_nxt.io_sync  = {s_r.io_sync[1:0], io_in};

        // Stop detection only reports; no state is dropped on a stop
        // Threshold is twice the slowest legal card clock period
        if (clk_edge) begin
            s_nxt.stop_cnt    = '0;
            s_nxt.clk_stopped = 1'b0;
        end else if (s_r.stop_cnt >= `CCSB_STOP_W'(`CCSB_STOP_CYC)) begin
            s_nxt.clk_stopped = 1'b1;
        end else begin
            s_nxt.stop_cnt = s_r.stop_cnt + `CCSB_STOP_W'(1);
        end

        // Rate: 372 during answer-to-reset, negotiated only after success
        if (atr_active_in) begin
            s_nxt.div = `CCSB_ETU_DEFAULT;
        end else if (pps_ok_in && pps_div_in != '0) begin
            s_nxt.div = pps_div_in;
        end

        // Sleep acknowledgement request; a new request wins over the clear
        if (sleep_ok_in) begin
            s_nxt.sleep_pend = 1'b1;
        end

        // Character transmitter, open drain: drive only the low bits
        case (s_r.tx_st)
            CCSB_TX_IDLE: begin
                s_nxt.io_oe   = 1'b0;
                s_nxt.bit_cnt = '0;
                if (s_r.rx_busy) begin
                    s_nxt.tx_st = CCSB_TX_IDLE;
                end else if (s_r.sleep_pend) begin
                    s_nxt.frame      = mk_frame(`CCSB_SW1_OK);
                    s_nxt.sleep_pend = sleep_ok_in;
                    s_nxt.sw2_pend   = 1'b1;
                    s_nxt.tx_st      = CCSB_TX_BITS;
                    s_nxt.io_oe      = 1'b1;
                end else if (s_r.sw2_pend) begin
                    s_nxt.frame    = mk_frame(`CCSB_SW2_OK);
                    s_nxt.sw2_pend = 1'b0;
                    s_nxt.tx_st    = CCSB_TX_BITS;
                    s_nxt.io_oe    = 1'b1;
                end else if (tx_valid_in) begin
                    s_nxt.frame = mk_frame(tx_data_in);
                    s_nxt.tx_st = CCSB_TX_BITS;
                    s_nxt.io_oe = 1'b1;
                end
            end
            CCSB_TX_BITS: begin
                if (etu.etu_tick) begin
                    s_nxt.bit_cnt = nib_inc(s_r.bit_cnt);
                    s_nxt.frame   = {1'b1, s_r.frame[9:1]};
                    if (nib_inc(s_r.bit_cnt) >= `CCSB_FRAME_BITS) begin
                        s_nxt.io_oe = 1'b0;
                        s_nxt.tx_st = CCSB_TX_GUARD;
                    end else begin
                        s_nxt.io_oe = ~s_r.frame[1];
                    end
                end
            end
            CCSB_TX_GUARD: begin
                // Line released for the guard time before the next character
                if (etu.etu_tick) begin
                    s_nxt.bit_cnt = nib_inc(s_r.bit_cnt);
                    if (nib_inc(s_r.bit_cnt) >= `CCSB_GUARD_END) begin
                        s_nxt.tx_st = CCSB_TX_IDLE;
                    end
                end
            end
            default: begin
                s_nxt.tx_st = CCSB_TX_IDLE;
                s_nxt.io_oe = 1'b0;
            end
        endcase

        // Receive activity: a start edge opens a one-character window
        // Our own start bits land while sending, so they open no window
        if (s_r.tx_st == CCSB_TX_IDLE && !s_r.rx_busy && io_fall) begin
            s_nxt.rx_busy = 1'b1;
            s_nxt.rx_cnt  = '0;
        end else if (s_r.rx_busy && etu.etu_tick) begin
            s_nxt.rx_cnt = nib_inc(s_r.rx_cnt);
            if (nib_inc(s_r.rx_cnt) >= `CCSB_RX_ETUS) begin
                s_nxt.rx_busy = 1'b0;
            end
        end

        // Operating while executing, sending or receiving; idle otherwise.
        // Taken from the next state so the flag keeps pace with receive, send and pending state; cmd_busy_in shows one cycle later.
        s_nxt.op_state = cmd_busy_in || s_nxt.rx_busy || s_nxt.sleep_pend
                         || s_nxt.sw2_pend || s_nxt.tx_st != CCSB_TX_IDLE;
    end

    // Single state register; async reset loads constants only
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_r          <= '0;
            s_r.clk_sync <= `CCSB_SYNC_IDLE;
            s_r.io_sync  <= `CCSB_SYNC_IDLE;
            s_r.div      <= `CCSB_ETU_DEFAULT;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs; the line is only ever pulled low
    assign io_out          = 1'b0;
    assign io_oe_out       = s_r.io_oe;
    assign op_state_out    = s_r.op_state;
    assign clk_stopped_out = s_r.clk_stopped;
    assign rx_busy_out     = s_r.rx_busy;
    assign etu_div_out     = s_r.div;

    // Characteristics byte 1 carries only the fast-clock need flag
    always_comb begin
        fchar_byte1_out = 8'h00;
        fchar_byte1_out[`CCSB_FCHAR_FAST_BIT] = needs_fast_clk_in;
    end

endmodule

// ==== test/ccsb_card_props.sv ====
// Checker for the card controller ports.
// Bound to ccsb_card_ctrl below; sees its ports only.
`timescale 1ns/1ps
module ccsb_card_props (
    // Clock and reset
    input wire logic        sys_clk_in,
    input wire logic        reset_n_in,
    // Ports watched
    input wire logic        cmd_busy_in,
    input wire logic        atr_active_in,
    input wire logic        pps_ok_in,
    input wire logic [11:0] pps_div_in,
    input wire logic        needs_fast_clk_in,
    input wire logic        sleep_ok_in,
    input wire logic        tx_ready_out,
    input wire logic        io_oe_out,
    input wire logic [7:0]  fchar_byte1_out,
    input wire logic        op_state_out,
    input wire logic        clk_stopped_out,
    input wire logic        rx_busy_out,
    input wire logic [11:0] etu_div_out
);
    // One domain, so one clock and reset for all
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    AST_FAST_FLAG: assert property (fchar_byte1_out == {5'h00, needs_fast_clk_in, 2'h0})
        else $error("fast flag wrong");
    AST_CMD_OP: assert property (cmd_busy_in |=> op_state_out)
        else $error("idle while busy");
    AST_RX_OP: assert property (rx_busy_out |-> op_state_out)
        else $error("idle while receiving");
    AST_IDLE: assert property ((!cmd_busy_in && tx_ready_out && !rx_busy_out) [*3]
        |-> !op_state_out) else $error("operating while quiet");
    AST_ATR_RATE: assert property (atr_active_in |=> etu_div_out == 12'h174)
        else $error("reset answer rate wrong");
    AST_PPS_LOAD: assert property ((pps_ok_in && !atr_active_in && pps_div_in != 12'h000)
        |=> etu_div_out == $past(pps_div_in)) else $error("rate not loaded");
    AST_RATE_KEEP: assert property (!pps_ok_in && !atr_active_in |=> $stable(etu_div_out))
        else $error("rate changed");
    AST_SLEEP_WAIT: assert property (sleep_ok_in |=> !tx_ready_out)
        else $error("status words not queued");
    // A stopped card clock must freeze the line driver
    AST_STOP_FREEZE: assert property (clk_stopped_out && $past(clk_stopped_out)
        |-> $stable(io_oe_out)) else $error("line moved while stopped");
endmodule

bind ccsb_card_ctrl ccsb_card_props u_props (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cmd_busy_in(cmd_busy_in),
    .atr_active_in(atr_active_in), .pps_ok_in(pps_ok_in), .pps_div_in(pps_div_in),
    .needs_fast_clk_in(needs_fast_clk_in), .sleep_ok_in(sleep_ok_in),
    .tx_ready_out(tx_ready_out), .io_oe_out(io_oe_out), .fchar_byte1_out(fchar_byte1_out),
    .op_state_out(op_state_out), .clk_stopped_out(clk_stopped_out),
    .rx_busy_out(rx_busy_out), .etu_div_out(etu_div_out));

// ==== test/ccsb_term_model.sv ====
// Terminal model: card clock source with stop control and wait counters.
// Assumes the card permits a stop after 1860 quiet card clocks; force_in lets the bench stop it at once.
`timescale 1ns/1ps
module ccsb_term_model #(
    parameter int HALF_NS = 153
) (
    // Bench commands
    input  wire logic stop_in,
    input  wire logic force_in,
    // Card pins and the bench may-send flag
    input  wire logic io_in,
    output logic      card_clk_out,
    output logic      may_send_out
);
    int   idle_cnt = 0;
    int   run_cnt  = 744;
    logic run      = 1'b1;
    // About 3.27 MHz, 50 % duty, stands low while stopped
    // One process owns the clock and both counters, so none has two writers
    initial begin
        card_clk_out = 1'b0;
        forever begin
            #(HALF_NS);
            // Stop after the quiet count unless told to misbehave
            if (stop_in && (force_in || idle_cnt >= 1860)) begin
                run = 1'b0;
            end else if (!stop_in && !run) begin
                run     = 1'b1;
                run_cnt = 0;
            end
            card_clk_out = run & ~card_clk_out;
            // Counted on the card clock; a low line restarts the quiet count
            if (card_clk_out) begin
                idle_cnt = io_in ? idle_cnt + 1 : 0;
                run_cnt  = run_cnt + 1;
            end
        end
    end
    assign may_send_out = (run_cnt >= 744);
endmodule

// ==== test/tb_top.sv ====
// Bench for the card controller: rate, framing, sleep answer, stop, activity.
// Assumes the terminal model makes the card clock; the line has a pull-up.
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        busy = 1'b0, atr = 1'b0, pps_ok = 1'b0, fast = 1'b0, slp = 1'b0;
    logic        tx_valid = 1'b0, stop = 1'b0, frc = 1'b0, term_low = 1'b0;
    logic [11:0] pps_div = 12'h000;
    logic [7:0]  tx_data = 8'h00;
    logic        card_clk, io_oe, io_out, ready, op, stopped, rx_busy, may_send;
    logic [7:0]  fchar;
    logic [11:0] div;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    // Open drain with pull-up
    wire         io_w = !((io_oe && !io_out) || term_low);

    always #50 sys_clk_in = ~sys_clk_in;

    ccsb_card_ctrl u_dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .card_clk_in(card_clk), .io_in(io_w), .io_out(io_out), .io_oe_out(io_oe),
        .cmd_busy_in(busy), .atr_active_in(atr), .pps_ok_in(pps_ok), .pps_div_in(pps_div),
        .needs_fast_clk_in(fast), .sleep_ok_in(slp), .tx_valid_in(tx_valid),
        .tx_data_in(tx_data), .tx_ready_out(ready), .fchar_byte1_out(fchar),
        .op_state_out(op), .clk_stopped_out(stopped), .rx_busy_out(rx_busy),
        .etu_div_out(div));
    ccsb_term_model u_term (.stop_in(stop), .force_in(frc), .io_in(io_w),
        .card_clk_out(card_clk), .may_send_out(may_send));

    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] seen);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Hang guard, well above the whole sequence
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    // Mid-bit sampling on card clocks, so a stopped clock only pauses it
    task automatic rx_char(input int d, output logic [7:0] b);
        int i;
        for (i = 0; i < 20000 && io_w; i++)
            tick(1);
        repeat (d / 2) @(posedge card_clk);
        chk("start", 12'h000, io_w);
        chk("op_tx", 12'h001, op);
        for (i = 0; i < 8; i++) begin
            repeat (d) @(posedge card_clk);
            b[i] = io_w;
        end
        repeat (d) @(posedge card_clk);
        chk("parity", ^b, io_w);
        repeat (d) @(posedge card_clk);
        chk("guard", 12'h001, io_w);
    endtask
    task automatic send(input logic [7:0] v, input int d);
        logic [7:0] b;
        int i;
        for (i = 0; i < 20000 && ready !== 1'b1; i++)
            tick(1);
        tx_valid = 1'b1;
        tx_data = v;
        tick(1);
        tx_valid = 1'b0;
        rx_char(d, b);
        chk("tx_byte", v, b);
    endtask
    task automatic set_pps(input logic [11:0] v, input logic a);
        atr = a;
        pps_div = v;
        pps_ok = 1'b1;
        tick(1);
        pps_ok = 1'b0;
        atr = 1'b0;
        tick(1);
    endtask

    task automatic t_reset;
        chk("op", 12'h000, op);
        chk("io_out", 12'h000, io_out);
        chk("div", 12'h174, div);
        fast = 1'b1;
        tick(1);
        chk("fchar", 12'h004, fchar);
        fast = 1'b0;
    endtask
    task automatic t_rate;
        atr = 1'b1;
        send(8'ha5, 372);
        atr = 1'b0;
        set_pps(12'h000, 1'b0);
        chk("div_zero", 12'h174, div);
        set_pps(12'h010, 1'b1);
        chk("div_atr", 12'h174, div);
        set_pps(12'h010, 1'b0);
        chk("div_pps", 12'h010, div);
        send(8'h3c, 16);
    endtask
    // Legacy sleep only; the terminal model itself never issues it
    task automatic t_sleep;
        logic [7:0] b;
        slp = 1'b1;
        tick(1);
        slp = 1'b0;
        rx_char(16, b);
        chk("sw1", 12'h090, b);
        rx_char(16, b);
        chk("sw2", 12'h000, b);
    endtask
    task automatic t_stop;
        fork
            send(8'h5a, 16);
            begin
                tick(200);
                frc = 1'b1;
                stop = 1'b1;
                tick(60);
                chk("stopped", 12'h001, stopped);
                chk("op_stop", 12'h001, op);
                stop = 1'b0;
                frc = 1'b0;
            end
        join
    endtask
    task automatic t_busy;
        int i;
        for (i = 0; i < 4000 && !may_send; i++)
            tick(1);
        chk("may_send", 12'h001, may_send);
        busy = 1'b1;
        tick(2);
        chk("op_cmd", 12'h001, op);
        busy = 1'b0;
        tick(3);
        chk("op_idle", 12'h000, op);
        term_low = 1'b1;
        repeat (16) @(posedge card_clk);
        #1 term_low = 1'b0;
        tick(2);
        chk("rx_busy", 12'h001, rx_busy);
        tick(900);
        chk("rx_end", 12'h000, rx_busy);
        chk("op_end", 12'h000, op);
    endtask
    // Legal stop: the model holds the clock until the line has been quiet long enough
    task automatic t_idle_stop;
        stop = 1'b1;
        tick(1000);
        chk("early_stop", 12'h000, stopped);
        tick(6000);
        chk("idle_stop", 12'h001, stopped);
        chk("op_idle_stop", 12'h000, op);
        stop = 1'b0;
        tick(30);
        chk("restarted", 12'h000, stopped);
    endtask

    initial begin
        repeat (5) @(posedge sys_clk_in);
        #1 reset_n_in = 1'b1;
        tick(1);
        t_reset();
        t_rate();
        t_sleep();
        t_stop();
        t_busy();
        t_idle_stop();
        summarize();
    end
endmodule
